// ---- verilog/i2c_stop_unit.v ----
// Serial port master: stop sequence with collision checks, baud clock
// bursts, AXI4-Lite registers and a masked level interrupt.
// Assumes SDA and SCL are open-drain with external pull-ups, inputs
// already synchronous to aclk.
`timescale 1ns/1ps
`include "i2c_stop_unit_consts.vh"

module i2c_stop_unit
#(
	parameter PRESCALE = `BAUD_PRESCALE
)
(
	input wire aclk,
	input wire aresetn,
	input wire [5:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [5:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	output reg spi_clk_ff,
	output wire irq
);

	localparam ST_IDLE = 3'd0;
	localparam ST_SDA_LOW = 3'd1;
	localparam ST_SCL_REL = 3'd2;
	localparam ST_SCL_HIGH = 3'd3;
	localparam ST_SDA_REL = 3'd4;
	localparam ST_STOP_WAIT = 3'd5;

	localparam SEL_RELOAD = 4'd0;
	localparam SEL_BUFFER = 4'd1;
	localparam SEL_CTRL1 = 4'd2;
	localparam SEL_CTRL2 = 4'd3;
	localparam SEL_CTRL3 = 4'd4;
	localparam SEL_MASK = 4'd5;
	localparam SEL_STATUS = 4'd6;
	localparam SEL_IRQ_STAT = 4'd7;
	localparam SEL_IRQ_MASK = 4'd8;
	localparam SEL_NONE = 4'd15;

	// Address decode shared by the read and the write path
	function [3:0] reg_sel;
		input [5:0] addr;
		begin
			case (addr)
			`OFF_RELOAD: reg_sel = SEL_RELOAD;
			`OFF_BUFFER: reg_sel = SEL_BUFFER;
			`OFF_CTRL1: reg_sel = SEL_CTRL1;
			`OFF_CTRL2: reg_sel = SEL_CTRL2;
			`OFF_CTRL3: reg_sel = SEL_CTRL3;
			`OFF_ADDR_MASK: reg_sel = SEL_MASK;
			`OFF_STATUS: reg_sel = SEL_STATUS;
			`OFF_IRQ_STAT: reg_sel = SEL_IRQ_STAT;
			`OFF_IRQ_MASK: reg_sel = SEL_IRQ_MASK;
			default: reg_sel = SEL_NONE;
			endcase
		end
	endfunction

	reg [5:0] awaddr_ff;
	reg aw_got_ff;
	reg [7:0] wdata_ff;
	reg wstrb0_ff;
	reg w_got_ff;
	reg [7:0] reload_ff;
	reg [7:0] buffer_ff;
	reg [7:0] ctrl1_ff;
	reg [7:0] ctrl2_ff;
	reg [7:0] ctrl3_ff;
	reg [7:0] addr_mask_ff;
	reg stop_seen_ff;
	reg [`IRQ_W-1:0] irq_stat_ff;
	reg [`IRQ_W-1:0] irq_mask_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg burst_ff;
	reg [4:0] halves_ff;
	reg coll;
	reg stop_done;
	reg stop_hit;
	reg brg_load;
	wire brg_timeout;
	wire wr_fire;
	wire [3:0] wr_sel;
	wire [3:0] mode;
	wire port_en;
	wire i2c_mode;
	wire master_mode;
	wire stop_go;
	wire buf_wr;
	wire buf_ok;
	wire brg_run;
	wire [7:0] status_val;

	// ------------------------------------------------------------
	// AXI4-Lite write and read channels
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;
	assign wr_sel = reg_sel(awaddr_ff);

	// Address and data are latched apart so either may come first
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 6'h00;
			wdata_ff <= `REG_RESET;
			wstrb0_ff <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata[7:0];
				wstrb0_ff <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == SEL_NONE) ? `RESP_SLVERR
					: `RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign status_val = {3'b000, stop_seen_ff, 1'b0,
		burst_ff || (state_ff != ST_IDLE), 2'b00};

	// Read data is registered in the cycle the address is taken
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (reg_sel(s_axi_araddr))
			SEL_RELOAD: s_axi_rdata <= {24'h000000, reload_ff};
			SEL_BUFFER: s_axi_rdata <= {24'h000000, buffer_ff};
			SEL_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_ff};
			SEL_CTRL2: s_axi_rdata <= {24'h000000, ctrl2_ff};
			SEL_CTRL3: s_axi_rdata <= {24'h000000, ctrl3_ff};
			SEL_MASK: s_axi_rdata <= {24'h000000, addr_mask_ff};
			SEL_STATUS: s_axi_rdata <= {24'h000000, status_val};
			SEL_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_ff};
			SEL_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_ff};
			default:
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `RESP_SLVERR;
			end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// Mode decode and start conditions
	// ------------------------------------------------------------
	assign mode = ctrl1_ff[`CTRL1_MODE_HI:0];
	assign port_en = ctrl1_ff[`CTRL1_EN];
	assign i2c_mode = (mode == `MODE_I2C_MASTER);
	assign master_mode = i2c_mode || (mode == `MODE_SPI_MASTER);
	assign stop_go = port_en && i2c_mode && ctrl2_ff[`CTRL2_STOP]
		&& !burst_ff;
	assign buf_wr = wr_fire && wstrb0_ff && (wr_sel == SEL_BUFFER);
	// A buffer write is refused while a sequence or a burst is running
	assign buf_ok = port_en && master_mode && !burst_ff
		&& (state_ff == ST_IDLE) && !stop_go;

	// ------------------------------------------------------------
	// Stop sequence state machine
	// ------------------------------------------------------------
	always @*
	begin
		nxt_state = state_ff;
		coll = 1'b0;
		stop_done = 1'b0;
		stop_hit = 1'b0;
		brg_load = 1'b0;
		case (state_ff)
		ST_IDLE:
			if (stop_go)
				nxt_state = ST_SDA_LOW;
		ST_SDA_LOW:
			if (!sda_in)
				nxt_state = ST_SCL_REL;
		ST_SCL_REL:
			if (scl_in)
			begin
				nxt_state = ST_SCL_HIGH;
				brg_load = 1'b1;
			end
		ST_SCL_HIGH:
			if (!scl_in)
				coll = 1'b1;
			else if (brg_timeout)
			begin
				nxt_state = ST_SDA_REL;
				brg_load = 1'b1;
			end
		ST_SDA_REL:
			if (!scl_in && !sda_in)
				coll = 1'b1;
			else if (brg_timeout)
			begin
				if (!sda_in)
					coll = 1'b1;
				else
				begin
					stop_hit = 1'b1;
					nxt_state = ST_STOP_WAIT;
					brg_load = 1'b1;
				end
			end
		ST_STOP_WAIT:
			if (brg_timeout)
			begin
				stop_done = 1'b1;
				nxt_state = ST_IDLE;
			end
		default:
			nxt_state = ST_IDLE;
		endcase
		if (coll)
			nxt_state = ST_IDLE;
		if (!port_en)
			nxt_state = ST_IDLE;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Open drain: only ever pull low, release lets the line float
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign sda_oe = (state_ff == ST_SDA_LOW) || (state_ff == ST_SCL_REL)
		|| (state_ff == ST_SCL_HIGH);
	assign scl_oe = (state_ff == ST_SDA_LOW)
		|| (burst_ff && i2c_mode && !spi_clk_ff)
		|| (!burst_ff && i2c_mode && port_en && !spi_clk_ff);

	// ------------------------------------------------------------
	// Baud counter and clock bursts
	// ------------------------------------------------------------
	assign brg_run = burst_ff || (state_ff == ST_SCL_HIGH)
		|| (state_ff == ST_SDA_REL) || (state_ff == ST_STOP_WAIT);

	baud_counter #(.PRESCALE(PRESCALE)) u_baud_counter
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.load(brg_load || (buf_wr && buf_ok)),
		.run(brg_run),
		.reload_value(reload_ff),
		.timeout_ff(brg_timeout)
	);

	// Each timeout is one half period; the level holds once stopped
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			burst_ff <= 1'b0;
			halves_ff <= 5'h00;
			spi_clk_ff <= 1'b1;
		end
		else if (!port_en)
		begin
			burst_ff <= 1'b0;
			halves_ff <= 5'h00;
		end
		else if (buf_wr && buf_ok)
		begin
			burst_ff <= 1'b1;
			halves_ff <= `BURST_HALVES;
		end
		else if (burst_ff && brg_timeout)
		begin
			spi_clk_ff <= !spi_clk_ff;
			halves_ff <= halves_ff - 5'h01;
			if (halves_ff == 5'h01)
				burst_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control and status registers
	// ------------------------------------------------------------
	// Hardware sets of the write-collision flag win over a clear
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reload_ff <= `REG_RESET;
			buffer_ff <= `REG_RESET;
			ctrl1_ff <= `REG_RESET;
			ctrl2_ff <= `REG_RESET;
			ctrl3_ff <= `REG_RESET;
			addr_mask_ff <= `REG_RESET;
			stop_seen_ff <= 1'b0;
		end
		else
		begin
			if (wr_fire && wstrb0_ff)
			begin
				case (wr_sel)
				SEL_RELOAD: reload_ff <= wdata_ff;
				SEL_CTRL1: ctrl1_ff <= {wdata_ff[`CTRL1_WCOL]
					& ctrl1_ff[`CTRL1_WCOL], wdata_ff[6:0]};
				SEL_CTRL2: ctrl2_ff <= wdata_ff;
				SEL_CTRL3: ctrl3_ff <= wdata_ff;
				SEL_MASK: addr_mask_ff <= wdata_ff;
				default: ;
				endcase
			end
			if (buf_wr && buf_ok)
				buffer_ff <= wdata_ff;
			if (buf_wr && !buf_ok)
				ctrl1_ff[`CTRL1_WCOL] <= 1'b1;
			if (coll || stop_done || (!port_en && state_ff != ST_IDLE))
				ctrl2_ff[`CTRL2_STOP] <= 1'b0;
			if (stop_hit)
				stop_seen_ff <= 1'b1;
			else if (!port_en)
				stop_seen_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat_ff <= `IRQ_RESET;
			irq_mask_ff <= `IRQ_RESET;
		end
		else
		begin
			if (wr_fire && wstrb0_ff && wr_sel == SEL_IRQ_STAT)
				irq_stat_ff <= irq_stat_ff & ~wdata_ff[`IRQ_W-1:0];
			if (wr_fire && wstrb0_ff && wr_sel == SEL_IRQ_MASK)
				irq_mask_ff <= wdata_ff[`IRQ_W-1:0];
			if (stop_done)
				irq_stat_ff[`IRQ_EVENT] <= 1'b1;
			if (coll)
				irq_stat_ff[`IRQ_COLL] <= 1'b1;
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule // i2c_stop_unit

// ---- shared/i2c_stop_unit_consts.vh ----
// Named constants for the serial port stop-sequence and baud counter block.
// Assumes a 32-bit AXI4-Lite register bus with one 8-bit register per word.
`ifndef I2C_STOP_UNIT_CONSTS_VH
`define I2C_STOP_UNIT_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_RELOAD 6'h00
`define OFF_BUFFER 6'h04
`define OFF_CTRL1 6'h08
`define OFF_CTRL2 6'h0C
`define OFF_CTRL3 6'h10
`define OFF_ADDR_MASK 6'h14
`define OFF_STATUS 6'h18
`define OFF_IRQ_STAT 6'h1C
`define OFF_IRQ_MASK 6'h20

// ----------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------
`define CTRL1_WCOL 7
`define CTRL1_EN 5
`define CTRL1_MODE_HI 3
`define MODE_I2C_MASTER 4'h8
`define MODE_SPI_MASTER 4'hA
`define CTRL2_STOP 2
`define STAT_STOP_SEEN 4
`define STAT_BUSY 2
`define IRQ_EVENT 0
`define IRQ_COLL 1
`define IRQ_W 2

// ----------------------------------------------------------------
// Reset values, responses and counts
// ----------------------------------------------------------------
`define REG_RESET 8'h00
`define IRQ_RESET 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BURST_HALVES 5'h10
`define BAUD_PRESCALE 2

`endif

// ---- verilog/baud_counter.v ----
// Reloadable down-counter that times every serial clock half period.
// Assumes load and run come from the owning controller's registers.
`timescale 1ns/1ps
`include "i2c_stop_unit_consts.vh"

module baud_counter
#(
	parameter PRESCALE = `BAUD_PRESCALE
)
(
	input wire aclk,
	input wire aresetn,
	input wire load,
	input wire run,
	input wire [7:0] reload_value,
	output reg timeout_ff
);

	reg [7:0] count_ff;
	reg [7:0] pre_ff;
	wire tick;

	// ------------------------------------------------------------
	// Prescaler and count
	// ------------------------------------------------------------
	assign tick = (pre_ff == PRESCALE[7:0] - 8'h01);

	// Reload twice per serial period: once at each timeout
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_ff <= 8'h00;
			pre_ff <= 8'h00;
			timeout_ff <= 1'b0;
		end
		else if (load)
		begin
			count_ff <= reload_value;
			pre_ff <= 8'h00;
			timeout_ff <= 1'b0;
		end
		else if (run)
		begin
			pre_ff <= tick ? 8'h00 : pre_ff + 8'h01;
			timeout_ff <= tick && (count_ff == 8'h00);
			if (tick)
				count_ff <= (count_ff == 8'h00) ? reload_value
					: count_ff - 8'h01;
		end
		else
			timeout_ff <= 1'b0; // Stopped: counter holds its value
	end

endmodule // baud_counter

// ---- tb/i2c_stop_unit_props.sv ----
// Port checker for the stop unit: bus handshakes, stop and clock timing.
// Assumes software keeps the reload value at 3 or more.
`timescale 1ns/1ps
module i2c_stop_unit_props
#(
	parameter PRESCALE = 2
)
(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire scl_in,
	input wire scl_oe,
	input wire sda_in,
	input wire sda_oe,
	input wire spi_clk_ff
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// SCL may only float once SDA was seen low
	property p_scl_after_sda;
		$fell(scl_oe) && sda_oe |-> !$past(sda_in);
	endproperty
	a_scl_after_sda: assert property (p_scl_after_sda)
		else $error("SCL released before SDA seen low");
	// Clock pulled low under us: both lines let go quickly
	property p_scl_coll;
		sda_oe && !scl_oe && $past(!scl_oe) && $past(scl_in) && !scl_in
			|-> ##[1:2] (!sda_oe && !scl_oe);
	endproperty
	a_scl_coll: assert property (p_scl_coll)
		else $error("stop not aborted after SCL pulled low");
	// Shortest legal half period is eight cycles (reload 3)
	property p_half_period;
		$changed(spi_clk_ff) |=> $stable(spi_clk_ff) [*7];
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("serial clock half period too short");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready
			|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read answer dropped");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write answer dropped");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block)
		else $error("write taken while answer pending");
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write answer late");
	c_stop: cover property ($fell(scl_oe) && sda_oe);
	c_coll: cover property ($fell(sda_oe) && !sda_in);
	c_burst: cover property ($changed(spi_clk_ff));
endmodule // i2c_stop_unit_props

bind i2c_stop_unit i2c_stop_unit_props #(.PRESCALE(PRESCALE))
	u_i2c_stop_unit_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .scl_in(scl_in), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_oe(sda_oe), .spi_clk_ff(spi_clk_ff));

// ---- tb/bus_partner.sv ----
// Other masters and slaves on the two open-drain lines.
// Assumes pull-ups: a line is high unless some party pulls it low.
`timescale 1ns/1ps
module bus_partner
(
	input wire scl_oe,
	input wire sda_oe,
	input wire pull_scl,
	input wire pull_sda,
	output wire scl,
	output wire sda
);
	// Wired-AND; pulling SCL late models a slow or rival party
	assign scl = !(scl_oe || pull_scl);
	assign sda = !(sda_oe || pull_sda);
endmodule // bus_partner

// ---- tb/i2c_stop_unit_test.sv ----
// Register-level bench for the stop unit.
// Assumes the bus partner model and the bound port checker.
`timescale 1ns/1ps
`include "i2c_stop_unit_consts.vh"
module i2c_stop_unit_test;
	localparam RELOAD = 3;
	reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	reg pull_scl, pull_sda, prev;
	reg [5:0] awaddr, araddr;
	reg [31:0] wdata;
	reg [3:0] wstrb;
	wire awready, wready, bvalid, arready, rvalid, scl, sda;
	wire scl_oe, sda_oe, spi_clk_ff, irq, scl_out, sda_out;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer fails, comparisons, cycles, n, gap;
	i2c_stop_unit u_i2c_stop_unit (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .spi_clk_ff(spi_clk_ff), .irq(irq));
	bus_partner u_bus_partner (.scl_oe(scl_oe), .sda_oe(sda_oe),
		.pull_scl(pull_scl), .pull_sda(pull_sda), .scl(scl), .sda(sda));
	task check(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp)
			begin
				fails = fails + 1;
				$display("MISMATCH %0t saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	// Ready and answers are taken at the rising edge they qualify;
	// an idle edge at the end keeps back-to-back calls from double drives
	task wr(input [5:0] a, input [7:0] d, input [1:0] er);
		reg da, dw;
		begin
			awaddr <= a;
			wdata <= {24'h000000, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			da = 1'b0;
			dw = 1'b0;
			while (!(da && dw))
			begin
				@(posedge aclk);
				if (awready && !da) awvalid <= 1'b0;
				if (wready && !dw) wvalid <= 1'b0;
				da = da | awready;
				dw = dw | wready;
			end
			@(posedge aclk);
			while (!bvalid) @(posedge aclk);
			check(bresp, er);
			bready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task rd(input [5:0] a, input [7:0] ed, input [1:0] er);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			@(posedge aclk);
			while (!arready) @(posedge aclk);
			arvalid <= 1'b0;
			@(posedge aclk);
			while (!rvalid) @(posedge aclk);
			check(rdata, {24'h000000, ed});
			check(rresp, er);
			rready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task wait_irq;
		begin
			n = 0;
			while (!irq && n < 300)
			begin
				@(posedge aclk);
				n = n + 1;
			end
			check(irq, 1'b1);
		end
	endtask
	// Buffer write starts 16 half periods, then the level holds
	task burst(input [7:0] mode);
		begin
			wr(`OFF_CTRL1, mode, `RESP_OKAY);
			wr(`OFF_BUFFER, 8'hA5, `RESP_OKAY);
			prev = spi_clk_ff;
			n = 0;
			gap = 0;
			repeat (300)
			begin
				@(negedge aclk);
				gap = gap + 1;
				if (spi_clk_ff !== prev)
				begin
					if (n > 0) check(gap, 2 * (RELOAD + 1));
					if (!mode[1]) check(scl, spi_clk_ff);
					n = n + 1;
					gap = 0;
					prev = spi_clk_ff;
				end
			end
			check(n, 16);
			check(spi_clk_ff, 1'b1);
		end
	endtask
	task conclude;
		begin
			$display("comparisons %0d fails %0d", comparisons, fails);
			if (fails == 0 && comparisons > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Hang guard well above the expected run length
	always @(posedge aclk)
	begin
		cycles = cycles + 1;
		if (cycles == 6000)
		begin
			fails = fails + 1;
			conclude;
		end
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{pull_scl, pull_sda, awaddr, araddr, wdata} = 0;
		wstrb = 4'hF;
		{fails, comparisons, cycles} = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`OFF_RELOAD, `REG_RESET, `RESP_OKAY);
		rd(`OFF_STATUS, `REG_RESET, `RESP_OKAY);
		rd(6'h24, 8'h00, `RESP_SLVERR);
		wr(6'h24, 8'h5A, `RESP_SLVERR);
		wr(`OFF_RELOAD, RELOAD, `RESP_OKAY);
		// Byte lane zero off: the write is answered but lands nowhere
		wstrb <= 4'hE;
		wr(`OFF_RELOAD, 8'h77, `RESP_OKAY);
		wstrb <= 4'hF;
		rd(`OFF_RELOAD, RELOAD, `RESP_OKAY);
		wr(`OFF_IRQ_MASK, 8'h03, `RESP_OKAY);
		burst(8'h28);
		burst(8'h2A);
		// Clean stop on a quiet bus
		wr(`OFF_CTRL1, 8'h28, `RESP_OKAY);
		wr(`OFF_CTRL2, 8'h04, `RESP_OKAY);
		wait_irq;
		check({sda_oe, scl_oe}, 2'h0);
		rd(`OFF_STATUS, 8'h10, `RESP_OKAY);
		rd(`OFF_CTRL2, 8'h00, `RESP_OKAY);
		rd(`OFF_IRQ_STAT, 8'h01, `RESP_OKAY);
		wr(`OFF_IRQ_STAT, 8'h01, `RESP_OKAY);
		check(irq, 1'b0);
		// Rival holds SDA low through the stop
		wr(`OFF_CTRL1, 8'h00, `RESP_OKAY);
		wr(`OFF_CTRL1, 8'h28, `RESP_OKAY);
		pull_sda <= 1'b1;
		wr(`OFF_CTRL2, 8'h04, `RESP_OKAY);
		wr(`OFF_BUFFER, 8'h55, `RESP_OKAY);
		rd(`OFF_CTRL1, 8'hA8, `RESP_OKAY);
		wait_irq;
		pull_sda <= 1'b0;
		check({sda_oe, scl_oe}, 2'h0);
		rd(`OFF_IRQ_STAT, 8'h02, `RESP_OKAY);
		rd(`OFF_STATUS, 8'h00, `RESP_OKAY);
		rd(`OFF_CTRL2, 8'h00, `RESP_OKAY);
		// Rival pulls SCL low while it is high; collision left masked
		wr(`OFF_IRQ_STAT, 8'h02, `RESP_OKAY);
		wr(`OFF_IRQ_MASK, 8'h01, `RESP_OKAY);
		wr(`OFF_CTRL2, 8'h04, `RESP_OKAY);
		while (!(sda_oe && !scl_oe && scl)) @(negedge aclk);
		check({sda_out, scl_out}, 2'h0);
		repeat (2) @(posedge aclk);
		pull_scl <= 1'b1;
		repeat (4) @(posedge aclk);
		check({sda_oe, irq}, 2'h0);
		pull_scl <= 1'b0;
		rd(`OFF_IRQ_STAT, 8'h02, `RESP_OKAY);
		rd(`OFF_CTRL2, 8'h00, `RESP_OKAY);
		wr(`OFF_IRQ_MASK, 8'h03, `RESP_OKAY);
		check(irq, 1'b1);
		wr(`OFF_IRQ_STAT, 8'h02, `RESP_OKAY);
		check(irq, 1'b0);
		conclude;
	end
endmodule // i2c_stop_unit_test
